// file: shared/dram_host_pkg.sv
// Purpose: Constants and types for the 4K x 1 strobe-multiplexed DRAM host controller
// Assumes: 50 MHz clock; timing figures are the slowest speed grade
// Notes:   Times are kept in ns; cycle counts are derived from them
package dram_host_pkg;

    localparam int CLOCK_PERIOD_NS = 20;

    // Shortest whole count of cycles covering ns, never below one
    function automatic int ns_min_cycles(input int ns);
        int c;
        c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_min_cycles

    // Longest whole count of cycles within ns, never below one
    function automatic int ns_max_cycles(input int ns);
        int c;
        c = ns / CLOCK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_max_cycles

    function automatic int max_int(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max_int

    localparam int ADDR_W      = 12;
    localparam int HALF_ADDR_W = 6;
    localparam int ROW_COUNT   = 64;
    localparam int STEP_W      = 8;

    // Device timing, ns
    localparam int ROW_TO_COLUMN_LEAD_TIME_NS      = 110;
    localparam int ROW_TO_COLUMN_LEAD_MAX_NS       = 2000;
    localparam int ACCESS_FROM_ROW_STROBE_NS       = 350;
    localparam int ACCESS_FROM_COLUMN_STROBE_NS    = 200;
    localparam int ROW_PRECHARGE_TIME_NS           = 150;
    localparam int RANDOM_CYCLE_TIME_NS            = 500;
    localparam int READ_MODIFY_WRITE_CYCLE_TIME_NS = 700;
    localparam int COLUMN_PULSE_NS                 = 200;
    localparam int ROW_PULSE_NS                    = 350;
    localparam int ROW_HOLD_NS                     = 200;
    localparam int COLUMN_HOLD_NS                  = 350;
    localparam int READ_COMMAND_HOLD_NS            = 80;
    localparam int WRITE_PULSE_NS                  = 200;
    localparam int RMW_COLUMN_PULSE_NS             = 400;
    localparam int RMW_ROW_PULSE_NS                = 550;
    localparam int RMW_COLUMN_HOLD_NS              = 550;
    localparam int STROBE_TRAILING_EDGE_SKEW_NS    = 50;
    localparam int REFRESH_TIME_NS                 = 2000000;

    // Derived counts, in cycles after the row strobe falls
    localparam int LEAD_CYC      = ns_min_cycles(ROW_TO_COLUMN_LEAD_TIME_NS);
    localparam int LEAD_MAX_CYC  = ns_max_cycles(ROW_TO_COLUMN_LEAD_MAX_NS);
    localparam int SKEW_MAX_CYC  = ns_max_cycles(STROBE_TRAILING_EDGE_SKEW_NS);
    localparam int TRANSITION_CYC = 1;
    localparam int COL_ADDR_AT   = LEAD_CYC - 1;
    localparam int COL_FALL_AT   = LEAD_CYC;
    localparam int SAMPLE_AT     = max_int(ns_min_cycles(ACCESS_FROM_ROW_STROBE_NS),
        COL_FALL_AT + ns_min_cycles(ACCESS_FROM_COLUMN_STROBE_NS)) + TRANSITION_CYC;
    localparam int RW_END_AT     = max_int(max_int(ns_min_cycles(ROW_PULSE_NS),
        COL_FALL_AT + ns_min_cycles(ROW_HOLD_NS)),
        max_int(max_int(ns_min_cycles(COLUMN_HOLD_NS),
        COL_FALL_AT + ns_min_cycles(COLUMN_PULSE_NS)), SAMPLE_AT + 1));
    localparam int WE_FALL_AT    = SAMPLE_AT + 1;
    localparam int RMW_END_AT    = max_int(max_int(ns_min_cycles(RMW_ROW_PULSE_NS),
        COL_FALL_AT + ns_min_cycles(RMW_COLUMN_PULSE_NS)),
        max_int(ns_min_cycles(RMW_COLUMN_HOLD_NS), WE_FALL_AT + ns_min_cycles(WRITE_PULSE_NS)));
    localparam int RW_TOTAL      = max_int(RW_END_AT + ns_min_cycles(ROW_PRECHARGE_TIME_NS),
        ns_min_cycles(RANDOM_CYCLE_TIME_NS));
    localparam int RMW_TOTAL     = max_int(RMW_END_AT + ns_min_cycles(ROW_PRECHARGE_TIME_NS),
        ns_min_cycles(READ_MODIFY_WRITE_CYCLE_TIME_NS));
    // Leave room for one cycle in progress plus the idle and setup cycles
    localparam int REFRESH_ROW_INTERVAL_CYCLES =
        ns_max_cycles(REFRESH_TIME_NS / ROW_COUNT) - RMW_TOTAL - 2;

    localparam logic [STEP_W-1:0] STEP_COL_ADDR  = STEP_W'(COL_ADDR_AT);
    localparam logic [STEP_W-1:0] STEP_COL_FALL  = STEP_W'(COL_FALL_AT);
    localparam logic [STEP_W-1:0] STEP_SAMPLE    = STEP_W'(SAMPLE_AT);
    localparam logic [STEP_W-1:0] STEP_WE_FALL   = STEP_W'(WE_FALL_AT);
    localparam logic [STEP_W-1:0] STEP_RW_END    = STEP_W'(RW_END_AT);
    localparam logic [STEP_W-1:0] STEP_RMW_END   = STEP_W'(RMW_END_AT);
    localparam logic [STEP_W-1:0] STEP_SKEW      = STEP_W'(TRANSITION_CYC);
    localparam logic [STEP_W-1:0] STEP_RW_LAST   = STEP_W'(RW_TOTAL - 1);
    localparam logic [STEP_W-1:0] STEP_RMW_LAST  = STEP_W'(RMW_TOTAL - 1);

    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_REFRESH} op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_CYCLE} state_t;

endpackage : dram_host_pkg

// file: src/dram_refresh_timer.sv
// Purpose: Paces row refresh and walks the six-bit refresh row counter
// Assumes: Controller grants one refresh cycle per pending request
// Notes:   A tick in the grant cycle keeps the request pending
`timescale 1ns/100ps
`default_nettype none
module dram_refresh_timer
    import dram_host_pkg::*;
#(
    parameter int INTERVAL_CYCLES = REFRESH_ROW_INTERVAL_CYCLES,
    parameter int ROW_W           = HALF_ADDR_W
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_grant,
    output logic                  o_pending,
    output logic [ROW_W-1:0]      o_row
);
    logic [31:0] count;
    wire         tick = (count == 32'(INTERVAL_CYCLES - 1));

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
        end else begin
            count <= tick ? '0 : count + 32'd1;
        end
    end

    // Set wins over the grant so no interval is lost
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pending <= 1'b0;
            o_row     <= '0;
        end else begin
            o_pending <= tick | (o_pending & ~i_grant);
            if (i_grant) begin
                o_row <= o_row + ROW_W'(1);
            end
        end
    end
endmodule : dram_refresh_timer
`default_nettype wire

// file: src/dram_host_controller.sv
// Purpose: Host-side controller driving a 4K x 1 DRAM by row and column strobes
// Assumes: i_data_out is the device output already resolved and synchronous
// Notes:   One access at a time; refresh has priority over user requests
//
// How it works
// - Row strobe falls with row address bits stable; selects one of 64 rows.
// - Column strobe falls with column address bits and chip select stable.
// - Each cycle presents row bits first, then lowers the row strobe.
// - Chip select need only be valid when the column strobe falls.
// - Reads keep write enable high throughout the column strobe low time.
// - Read data sampled after the longer of the two access paths.
// - Column strobe falls no sooner than 110 ns, no later than 2000 ns.
// - Column strobe rises 0 to 50 ns after the row strobe rises.
// - Successive read or write cycles spaced at least 500 ns.
// - Read-modify-write cycles last at least 700 ns.
// - Every write enable low pulse lasts at least 200 ns.
// - Reads keep write enable high 80 ns after column strobe rises.
// - All 64 rows refreshed within 2 ms; any cycle refreshes its row.
// - Strobe pulse widths and row precharge always met before the next cycle.
// - Write enable drops before column strobe in writes, after the read sample in read-modify-write; data valid by then.
`timescale 1ns/100ps
`default_nettype none
module dram_host_controller
    import dram_host_pkg::*;
#(
    parameter int REFRESH_INTERVAL_CYCLES = REFRESH_ROW_INTERVAL_CYCLES
) (
    input  wire logic                   i_clock,
    input  wire logic                   i_rst,
    input  wire logic                   i_req,
    input  wire logic                   i_write,
    input  wire logic                   i_rmw,
    input  wire logic [ADDR_W-1:0]      i_addr,
    input  wire logic                   i_wdata,
    output logic                        o_ready,
    output logic                        o_rdata,
    output logic                        o_rdata_valid,
    output logic                        o_done,
    output logic                        o_row_strobe_n,
    output logic                        o_column_strobe_n,
    output logic                        o_chip_select_n,
    output logic                        o_write_enable_n,
    output logic [HALF_ADDR_W-1:0]      o_mem_address,
    output logic                        o_data_in,
    input  wire logic                   i_data_out
);
    // Operation returns read data
    function automatic logic op_reads(input op_t op);
        return (op == OP_READ) || (op == OP_RMW);
    endfunction : op_reads

    state_t                  state;
    op_t                     op;
    logic [STEP_W-1:0]       step;
    logic [HALF_ADDR_W-1:0]  row_bits;
    logic [HALF_ADDR_W-1:0]  column_bits;

    logic                    refresh_pending;
    logic [HALF_ADDR_W-1:0]  refresh_row;

    // Arbitration: refresh first, user only when no refresh waits
    wire take_refresh = (state == ST_IDLE) && refresh_pending;
    wire take_user    = (state == ST_IDLE) && !refresh_pending && i_req;
    assign o_ready    = (state == ST_IDLE) && !refresh_pending;

    wire op_t next_op = take_refresh ? OP_REFRESH :
                        i_rmw        ? OP_RMW :
                        i_write      ? OP_WRITE : OP_READ;

    // Per-operation end of the strobe low time and last step of the cycle
    wire [STEP_W-1:0] end_step  = (op == OP_RMW) ? STEP_RMW_END : STEP_RW_END;
    wire [STEP_W-1:0] last_step = (op == OP_RMW) ? STEP_RMW_LAST : STEP_RW_LAST;
    wire              cycle_end = (state == ST_CYCLE) && (step == last_step);

    wire state_t next_state = (state == ST_IDLE)  ? ((take_refresh || take_user) ? ST_SETUP
                                                                                 : ST_IDLE) :
                              (state == ST_SETUP) ? ST_CYCLE :
                              cycle_end           ? ST_IDLE : ST_CYCLE;
    wire [STEP_W-1:0] next_step = (state == ST_SETUP) ? '0 : step + STEP_W'(1);
    wire              in_cycle  = (next_state == ST_CYCLE);

    // Pin levels for the coming cycle, all timed from the row strobe fall
    wire next_row_low    = in_cycle && (next_step < end_step);
    wire col_phase       = in_cycle && (next_step >= STEP_COL_ADDR);
    wire next_column_low = in_cycle && (next_step >= STEP_COL_FALL)
                           && (next_step < end_step + STEP_SKEW);
    wire write_window    = (op == OP_WRITE) ? (next_step >= STEP_COL_ADDR) :
                           (op == OP_RMW)   ? (next_step >= STEP_WE_FALL) : 1'b0;
    // Reads never lower write enable, so its hold after the column strobe is free
    wire next_we_low     = in_cycle && write_window && (next_step < end_step);
    // Refresh keeps the device deselected so no cell is disturbed
    wire next_select_low = col_phase && (op != OP_REFRESH);

    wire [HALF_ADDR_W-1:0] user_row = i_addr[HALF_ADDR_W-1:0];
    wire [HALF_ADDR_W-1:0] next_address =
        (state == ST_IDLE) ? (take_refresh ? refresh_row : user_row) :
        col_phase          ? column_bits : row_bits;

    wire sample_now = (state == ST_CYCLE) && (step == STEP_SAMPLE) && op_reads(op);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            step  <= '0;
        end else begin
            state <= next_state;
            step  <= next_step;
        end
    end

    // Request capture; held stable for the whole cycle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            op          <= OP_READ;
            row_bits    <= '0;
            column_bits <= '0;
            o_data_in   <= 1'b0;
        end else if (take_refresh || take_user) begin
            op          <= next_op;
            row_bits    <= take_refresh ? refresh_row : user_row;
            column_bits <= take_refresh ? '0 : i_addr[ADDR_W-1:HALF_ADDR_W];
            o_data_in   <= take_refresh ? 1'b0 : i_wdata;
        end
    end

    // Strobes idle high; registered so the pins never glitch
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_row_strobe_n    <= 1'b1;
            o_column_strobe_n <= 1'b1;
            o_chip_select_n   <= 1'b1;
            o_write_enable_n  <= 1'b1;
            o_mem_address     <= '0;
        end else begin
            o_row_strobe_n    <= !next_row_low;
            o_column_strobe_n <= !next_column_low;
            o_chip_select_n   <= !next_select_low;
            o_write_enable_n  <= !next_we_low;
            o_mem_address     <= next_address;
        end
    end

    // Writes and refreshes return nothing, since the output is undefined then
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_rdata       <= 1'b0;
            o_rdata_valid <= 1'b0;
            o_done        <= 1'b0;
        end else begin
            o_rdata_valid <= sample_now;
            o_done        <= cycle_end && (op != OP_REFRESH);
            if (sample_now) begin
                o_rdata <= i_data_out;
            end
        end
    end

    dram_refresh_timer #(
        .INTERVAL_CYCLES (REFRESH_INTERVAL_CYCLES),
        .ROW_W           (HALF_ADDR_W)
    ) u_refresh (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_grant   (take_refresh),
        .o_pending (refresh_pending),
        .o_row     (refresh_row)
    );
endmodule : dram_host_controller
`default_nettype wire

// file: verif/dram_host_checker.sv
// Purpose: Pin sequencing assertions for the DRAM host controller
// Assumes: One clock is 20 ns; counts follow the controller's fixed step schedule
// Notes:   Bound to the controller; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module dram_host_checker
    import dram_host_pkg::*;
#(
    parameter int REFRESH_INTERVAL_CYCLES = REFRESH_ROW_INTERVAL_CYCLES
) (
    input wire logic                   i_clock,
    input wire logic                   i_rst,
    input wire logic                   i_req,
    input wire logic                   i_write,
    input wire logic                   i_rmw,
    input wire logic [ADDR_W-1:0]      i_addr,
    input wire logic                   o_ready,
    input wire logic                   o_rdata_valid,
    input wire logic                   o_done,
    input wire logic                   o_row_strobe_n,
    input wire logic                   o_column_strobe_n,
    input wire logic                   o_chip_select_n,
    input wire logic                   o_write_enable_n,
    input wire logic [HALF_ADDR_W-1:0] o_mem_address
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire                   take     = i_req && o_ready;
    wire [HALF_ADDR_W-1:0] row_bits = i_addr[5:0];
    wire [HALF_ADDR_W-1:0] col_bits = i_addr[11:6];

    a_row_first: assert property (take |-> ##2 $fell(o_row_strobe_n)
        && o_mem_address == $past(row_bits, 2)) else $error("row half missing at row strobe");
    a_col_select: assert property (take |-> ##8
        o_mem_address == $past(col_bits, 8) && !o_chip_select_n) else $error("column half bad");
    a_lead_time: assert property ($fell(o_row_strobe_n) |->
        o_column_strobe_n[*6] ##1 !o_column_strobe_n) else $error("column strobe lead wrong");
    a_trail_skew: assert property ($rose(o_row_strobe_n) |-> ##1
        ($rose(o_column_strobe_n) && o_row_strobe_n) ##1 o_row_strobe_n[*6])
        else $error("trailing skew or precharge wrong");
    a_cycle_space: assert property ($fell(o_row_strobe_n) |=>
        (!$fell(o_row_strobe_n))[*8] ##1 (!$fell(o_row_strobe_n))[*8]
        ##1 (!$fell(o_row_strobe_n))[*8]) else $error("cycles too close");
    a_write_pulse: assert property ($fell(o_write_enable_n) |->
        (!o_write_enable_n)[*8] ##1 (!o_write_enable_n)[*2]) else $error("write pulse short");
    a_read_hold: assert property ($rose(o_column_strobe_n) && o_write_enable_n |->
        o_write_enable_n[*4]) else $error("write enable fell too soon");
    a_read_no_write: assert property (take && !i_write && !i_rmw |-> ##1
        o_write_enable_n[*8] ##1 o_write_enable_n[*8] ##1 o_write_enable_n[*8])
        else $error("write enable low in read");
    a_answer_time: assert property (take && (i_rmw || !i_write) |-> ##22 o_rdata_valid)
        else $error("read answer late or early");
    a_rmw_length: assert property (take && i_rmw |-> ##40 o_done)
        else $error("rmw end wrong");
    a_refresh_desel: assert property ($fell(o_row_strobe_n) && !$past(take, 2) |-> ##7
        o_chip_select_n) else $error("refresh selected the device");
endmodule : dram_host_checker
bind dram_host_controller dram_host_checker #(
    .REFRESH_INTERVAL_CYCLES(REFRESH_INTERVAL_CYCLES)) u_checker (.*);
`default_nettype wire

// file: verif/dram_device_model.sv
// Purpose: Behavioural 4K x 1 strobe-multiplexed DRAM
// Assumes: Slowest timing grade; the strobes and the write enable fall are the only timing edges
// Notes:   A floating output shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module dram_device_model (
    input  wire logic       i_row_strobe_n,
    input  wire logic       i_column_strobe_n,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_write_enable_n,
    input  wire logic [5:0] i_mem_address,
    input  wire logic       i_data_in,
    output logic            o_data_out
);
    logic       mem [0:4095];
    logic [5:0] row;
    logic [5:0] col;
    logic       sel = 1'b0;
    logic       early = 1'b0;
    logic       drv = 1'b0;
    logic       q = 1'b0;
    realtime    t_row = 0;
    always @(negedge i_row_strobe_n) begin
        row = i_mem_address;
        t_row = $realtime;
    end
    always @(negedge i_column_strobe_n) begin
        col = i_mem_address;
        sel = !i_row_strobe_n && !i_chip_select_n;
        early = !i_write_enable_n;
        drv = 1'b0;
        if (sel) begin
            #200;
            if ($realtime - t_row < 350) #(350 - ($realtime - t_row));
            q = early ? 1'b1 : mem[{col, row}];
            drv = 1'b1;
        end
    end
    // Settle after the strobe block has latched column and select
    always @(negedge i_write_enable_n or negedge i_column_strobe_n) begin
        #1;
        if (!i_row_strobe_n && !i_column_strobe_n && !i_write_enable_n && sel)
            mem[{col, row}] = i_data_in;
    end
    assign o_data_out = drv ? q : ~q;
endmodule : dram_device_model
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the DRAM host controller
// Assumes: Device model answers at slowest-grade access time
// Notes:   Short refresh interval so every row cycles in a short run
`timescale 1ns/100ps
`default_nettype none
module testbench
    import dram_host_pkg::*;
;
    localparam int REF_CYC = 60;
    localparam int GAP_NS  = (REF_CYC + RMW_TOTAL + 4) * CLOCK_PERIOD_NS;
    // Clock starts low in its declaration so no false falling edge appears at time zero
    logic                   i_clock = 1'b0, i_rst, i_req, i_write, i_rmw, i_wdata, user, e;
    logic [ADDR_W-1:0]      i_addr, a;
    logic [HALF_ADDR_W-1:0] last_row;
    logic [31:0]            seed;
    op_t                    op;
    wire                    o_ready, o_rdata, o_rdata_valid, o_done, o_data_in, i_data_out;
    wire                    o_row_strobe_n, o_column_strobe_n, o_chip_select_n, o_write_enable_n;
    wire [HALF_ADDR_W-1:0]  o_mem_address;
    logic                   shadow [0:4095];
    logic                   exp_q [$];
    logic [ADDR_W-1:0]      corner [4] = '{12'h000, 12'hFFF, 12'h03F, 12'hFC0};
    int                     miscompares = 0, tests_run = 0, refreshes = 0, r0;
    time                    t_last;

    dram_host_controller #(.REFRESH_INTERVAL_CYCLES(REF_CYC)) DUT (.*);
    dram_device_model MEM (
        .i_row_strobe_n   (o_row_strobe_n),
        .i_column_strobe_n(o_column_strobe_n),
        .i_chip_select_n  (o_chip_select_n),
        .i_write_enable_n (o_write_enable_n),
        .i_mem_address    (o_mem_address),
        .i_data_in        (o_data_in),
        .o_data_out       (i_data_out)
    );
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_for(input logic on_ready);
        int n;
        n = 0;
        while ((on_ready ? o_ready : o_done) !== 1'b1) begin
            @(negedge i_clock);
            n++;
            if (n > 200) begin
                miscompares++;
                wrap_up();
            end
        end
    endtask : wait_for
    // Hold keeps a conflicting request up while busy; it must be ignored
    // Read-modify-write with a one bit also raises the plain write flag, which must lose
    task automatic access(input op_t o, input logic [ADDR_W-1:0] ad,
                          input logic d, input logic hold);
        wait_for(1'b1);
        i_req = 1'b1;
        i_write = (o == OP_WRITE) || ((o == OP_RMW) && d);
        i_rmw = (o == OP_RMW);
        i_addr = ad;
        i_wdata = d;
        user = 1'b1;
        if (o != OP_WRITE) exp_q.push_back(shadow[ad]);
        if (o != OP_READ) shadow[ad] = d;
        @(negedge i_clock);
        if (hold) begin
            i_write = 1'b1;
            i_rmw = 1'b0;
            i_wdata = ~d;
            repeat (5) @(negedge i_clock);
        end
        i_req = 1'b0;
        wait_for(1'b0);
        user = 1'b0;
    endtask : access
    always @(negedge i_clock) begin
        if (o_rdata_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bz;
            check("read bit", {11'h000, e}, {11'h000, o_rdata});
        end
    end
    always @(negedge o_row_strobe_n) begin
        if (user === 1'b0) begin
            if (refreshes > 0) begin
                check("refresh row", {6'h00, last_row + 6'h01}, {6'h00, o_mem_address});
                check("refresh gap", 12'h001, {11'h000, ($time - t_last) <= GAP_NS});
            end
            last_row = o_mem_address;
            t_last = $time;
            refreshes++;
        end
    end
    initial begin
        {i_rst, i_req, i_write, i_rmw, i_wdata, user, i_addr} = {1'b1, 17'h00000};
        seed = 32'h000127CF;
        repeat (6) @(negedge i_clock);
        i_rst = 1'b0;
        foreach (corner[i]) access(OP_WRITE, corner[i], i[0], 1'b0);
        foreach (corner[i]) access(OP_READ, corner[i], 1'b0, 1'b0);
        access(OP_RMW, 12'hFFF, 1'b0, 1'b0);
        access(OP_READ, 12'hFFF, 1'b0, 1'b1);
        access(OP_READ, 12'hFFF, 1'b0, 1'b0);
        $display("test fixed access done");
        for (int k = 0; k < 48; k++) begin
            seed = lfsr(seed);
            a = {seed[5:4], 4'h0, seed[3:2], 4'h0};
            op = (shadow[a] === 1'bx) ? OP_WRITE : op_t'(seed[7:6] == 2'b11 ? 2'b00 : seed[7:6]);
            access(op, a, seed[8], seed[9]);
        end
        $display("test random access done");
        r0 = refreshes;
        repeat (4000) @(negedge i_clock);
        check("refresh count", 12'h001, {11'h000, (refreshes - r0) >= ROW_COUNT});
        $display("test refresh done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
